// [hdl/src_ramp_trig_ctrl.sv]
// stepper ramp profile, trigger and gate control with APB registers
// Notes on behaviour
// - start pin is ORed with rear trigger input as the triggered-mode start.
// - both motor pins are read through the selected edge polarity.
// - mode A start ramps frequency from initial to maximum over ramp-up time.
// - at maximum, frequency holds until a slowdown condition.
// - mode A slowdown pin ramps frequency back to initial over ramp-down time.
// - after slowdown, generation continues at initial frequency until stop.
// - mode A without slowdown stays at maximum; stop pulse count always ends.
// - slowdown pin is ignored until maximum frequency is reached.
// - mode B ramps down automatically after the slowdown pulse count.
// - mode B slowdown pin stops at once; else stop pulse count ends.
// - continuous mode starts when configured, restarts after wait time.
// - triggered mode ignores wait; starts only on trigger or manual key.
// - manual key is a trigger, blocked while trigger pin sits at post-edge level.
// - positive polarity starts on rising edge, negative on falling edge.
// - triggered, no sweep or burst: one waveform cycle per trigger.
// - triggered sweep: trigger starts sweep, triggers during sweep ignored.
// - triggered burst: burst count cycles per trigger, triggers ignored meanwhile.
// - gate mode outputs while gate open by polarity or manual key held.
// - gate sweep starts on gate opening and ends early when gate closes.
// - motor modulation with gate mode forces continuous mode.
// - gate mode suppresses burst; stored burst setting kept for other modes.
// - slowdown and stop counts cover their full range at one-pulse resolution.
// - enabling motor modulation while sweep or burst is set warns one second, then clears them.
// - while stopped, open-collector output is off and pulse output low.
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/10ps
`include "src_cfg.svh"
module src_ramp_trig_ctrl
  import src_pkg::*;
#(
  parameter int unsigned WARN_CYCLES = `SRC_WARN_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rearTrigPin,
  input  wire logic        motor_start_pin,
  input  wire logic        motor_slowdown_stop_pin,
  input  wire logic        manual_fire_key,
  output logic      [31:0] freqWord,
  output logic             frontPulse,
  output logic             openCollectorOn,
  output logic             sweepStart,
  output logic             sweepActive,
  output logic             warnShow
);
  typedef logic [31:0] src_word_t;

  // all register storage
  logic [`SRC_CTRL_W-1:0] ctrl_ff;
  src_word_t initF_ff, maxF_ff, upStep_ff, dnStep_ff, wait_ff, sweepT_ff, prdata_ff;
  logic [`SRC_CNT_W-1:0]  slowN_ff, stopN_ff, burstN_ff, pulseCnt_ff;
  src_state_t             state_ff, nxt_state;
  src_word_t              freq_ff, nxt_freq, phase_ff, tmr_ff, nxt_tmr;
  logic [31:0]            warnCnt_ff;
  logic [3:0]             sync1_ff, sync2_ff;
  logic                   trigLvl_ff, manLvl_ff, gateLvl_ff, motor_ff;
  logic                   sweep_ff, nxt_sweep, pulse_ff, outOn_ff;

  // bus decode
  function automatic logic isAdr(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction
  wire       setup   = psel & ~penable;
  wire [7:0] adr     = {paddr[7:2], 2'h0};
  wire       adrHit  = (adr <= `SRC_ADR_PCNT) && (paddr[1:0] == 2'h0);
  // unmapped or unaligned writes are dropped, never folded onto a word
  wire       wrStb   = psel & penable & pwrite & adrHit;
  assign pready  = 1'b1;   // no wait states
  assign pslverr = psel & penable & ~adrHit;
  assign prdata  = prdata_ff;

  // configuration decoded from control bits
  wire        run     = ctrl_ff[`SRC_B_RUN];
  wire [1:0]  modeRaw = ctrl_ff[`SRC_B_MODE_HI:`SRC_B_MODE_LO];
  wire        motorEn = ctrl_ff[`SRC_B_MOTOR];
  wire        polNeg  = ctrl_ff[`SRC_B_POLNEG];
  wire        rampB   = ctrl_ff[`SRC_B_RAMPB];
  wire        isGate  = modeRaw == SRC_GATE;
  wire        isTrig  = modeRaw == SRC_TRIG;
  wire        sweepOn = ctrl_ff[`SRC_B_SWEEP];
  wire        burstOn = ctrl_ff[`SRC_B_BURST] & ~isGate;
  wire        warnRun = warnCnt_ff != 32'h0;
  wire        warnEnd = warnCnt_ff == 32'h1;
  // motor enable rising while sweep or burst set starts the warning
  wire        warnGo  = motorEn & ~motor_ff & (ctrl_ff[`SRC_B_SWEEP] | ctrl_ff[`SRC_B_BURST]);

  // pin levels after synchroniser, polarity applied to all but trigRaw and the key level
  wire trigRaw  = sync2_ff[0] | sync2_ff[1];
  wire trigLvl  = trigRaw ^ polNeg;
  wire slowAct  = sync2_ff[2] ^ polNeg;
  wire manLvl   = sync2_ff[3];
  // edge taken on the raw pin, so a polarity change alone fires nothing
  wire pinEdge  = polNeg ? (~trigRaw & trigLvl_ff) : (trigRaw & ~trigLvl_ff);
  // key press counts only while the pin rests at its idle level
  wire manFire  = manLvl & ~manLvl_ff & ~trigLvl;
  wire trigger  = pinEdge | manFire;
  wire gateOpen = (sync2_ff[0] ^ polNeg) | manLvl;
  wire gateRise = gateOpen & ~gateLvl_ff;

  // waveform cycle counting via phase accumulator carry
  wire [32:0] phSum    = {1'b0, phase_ff} + {1'b0, freq_ff};
  wire        cycDone  = phSum[32] & outOn_ff;
  wire [`SRC_CNT_W-1:0] cntInc = pulseCnt_ff + `SRC_CNT_W'(1);
  wire        stopHit  = cycDone && (cntInc >= stopN_ff);
  wire        slowHit  = cycDone && (cntInc >= slowN_ff);
  wire        burstHit = cycDone && (cntInc >= burstN_ff);
  wire        isIdle   = state_ff == SRC_IDLE;

  // linear ramp arithmetic, saturating at the end points
  wire [32:0] upSum  = {1'b0, freq_ff} + {1'b0, upStep_ff};
  wire [32:0] dnLim  = {1'b0, initF_ff} + {1'b0, dnStep_ff};
  wire        upDone = upSum >= {1'b0, maxF_ff};
  wire        dnDone = {1'b0, freq_ff} <= dnLim;

  // profile and generation sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_freq  = freq_ff;
    nxt_tmr   = tmr_ff;
    nxt_sweep = sweep_ff;
    case (state_ff)
      SRC_IDLE: begin
        nxt_freq = initF_ff;
        if (run && motorEn && !warnRun) begin
          if (!isTrig || trigger) begin
            nxt_state = SRC_UP;
          end
        end else if (run && !motorEn) begin
          if (isGate && gateOpen) begin
            nxt_state = SRC_RUN;
            nxt_sweep = sweepOn;
            nxt_tmr   = sweepT_ff;
          end else if (modeRaw == SRC_CONT) begin
            nxt_state = SRC_RUN;
          end else if (isTrig && trigger) begin
            nxt_state = SRC_RUN;
            nxt_sweep = sweepOn;
            nxt_tmr   = sweepT_ff;
          end
        end
      end
      SRC_UP: begin
        nxt_freq = upDone ? maxF_ff : upSum[31:0];
        if (upDone) begin
          nxt_state = SRC_MAX;
        end
        if (stopHit) begin
          nxt_state = SRC_WAIT;
        end
      end
      SRC_MAX: begin
        nxt_freq = maxF_ff;
        if (!rampB && slowAct) begin
          nxt_state = SRC_DN;
        end else if (rampB && slowHit) begin
          nxt_state = SRC_DN;
        end
        if (stopHit || (rampB && slowAct)) begin
          nxt_state = SRC_WAIT;
        end
      end
      SRC_DN: begin
        nxt_freq = dnDone ? initF_ff : freq_ff - dnStep_ff;
        if (dnDone) begin
          nxt_state = SRC_LOW;
        end
        if (stopHit || (rampB && slowAct)) begin
          nxt_state = SRC_WAIT;
        end
      end
      SRC_LOW: begin
        nxt_freq = initF_ff;
        if (stopHit || (rampB && slowAct)) begin
          nxt_state = SRC_WAIT;
        end
      end
      SRC_WAIT: begin
        // triggered mode skips the wait entirely
        nxt_freq = initF_ff;
        if (isTrig || !run || !motorEn) begin
          nxt_state = SRC_IDLE;
        end else if (tmr_ff >= wait_ff) begin
          nxt_state = SRC_UP;
        end
      end
      SRC_RUN: begin
        nxt_freq = initF_ff;
        if (sweep_ff) begin
          nxt_tmr = tmr_ff - 32'h1;
        end
        if (!run || motorEn) begin
          nxt_state = SRC_IDLE;
        end else if (isGate) begin
          if (!gateOpen) begin
            nxt_state = SRC_IDLE;
          end
          if (gateRise && sweepOn) begin
            nxt_sweep = 1'b1;
            nxt_tmr   = sweepT_ff;
          end else if (sweep_ff && tmr_ff == 32'h0) begin
            nxt_sweep = 1'b0;
          end
        end else if (isTrig) begin
          // triggers are not looked at here, so repeats are ignored
          if (sweepOn ? (tmr_ff == 32'h0) : burstOn ? burstHit : cycDone) begin
            nxt_state = SRC_IDLE;
          end
        end else if (modeRaw != SRC_CONT) begin
          nxt_state = SRC_IDLE;
        end
      end
      default: nxt_state = SRC_IDLE;
    endcase
    if (!run) begin
      nxt_state = SRC_IDLE;
    end
    if (state_ff != SRC_WAIT && nxt_state == SRC_WAIT) begin
      nxt_tmr = 32'h0;
    end else if (state_ff == SRC_WAIT) begin
      nxt_tmr = tmr_ff + 32'h1;
    end
    if (nxt_state != SRC_RUN) begin
      nxt_sweep = 1'b0;
    end
  end

  // synchronisers and edge history
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_ff   <= 4'h0;
      sync2_ff   <= 4'h0;
      trigLvl_ff <= 1'b0;
      manLvl_ff  <= 1'b0;
      gateLvl_ff <= 1'b0;
      motor_ff   <= 1'b0;
    end else begin
      sync1_ff   <= {manual_fire_key, motor_slowdown_stop_pin, motor_start_pin, rearTrigPin};
      sync2_ff   <= sync1_ff;
      trigLvl_ff <= trigRaw;
      manLvl_ff  <= manLvl;
      gateLvl_ff <= gateOpen;
      motor_ff   <= motorEn;
    end
  end

  // sequencer state, frequency, cycle counter
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff    <= SRC_IDLE;
      freq_ff     <= 32'h0;
      tmr_ff      <= 32'h0;
      sweep_ff    <= 1'b0;
      phase_ff    <= 32'h0;
      pulseCnt_ff <= '0;
      outOn_ff    <= 1'b0;
      pulse_ff    <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      freq_ff     <= nxt_freq;
      tmr_ff      <= nxt_tmr;
      sweep_ff    <= nxt_sweep;
      outOn_ff    <= !(nxt_state == SRC_IDLE || nxt_state == SRC_WAIT);
      phase_ff    <= outOn_ff ? phSum[31:0] : 32'h0;   // each run starts at phase zero
      pulseCnt_ff <= !outOn_ff ? '0 : cycDone ? cntInc : pulseCnt_ff;
      pulse_ff    <= outOn_ff & phSum[31];
    end
  end

  // control register with hardware overrides after software writes
  logic [`SRC_CTRL_W-1:0] ctrlWr;
  assign ctrlWr = (wrStb && isAdr(adr, `SRC_ADR_CTRL)) ? pwdata[`SRC_CTRL_W-1:0] : ctrl_ff;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff    <= `SRC_CTRL_RST;
      warnCnt_ff <= 32'h0;
    end else begin
      ctrl_ff <= ctrlWr;
      if (ctrlWr[`SRC_B_MOTOR] && ctrlWr[`SRC_B_MODE_HI:`SRC_B_MODE_LO] == SRC_GATE) begin
        ctrl_ff[`SRC_B_MODE_HI:`SRC_B_MODE_LO] <= SRC_CONT;
      end
      if (warnEnd && motorEn) begin
        ctrl_ff[`SRC_B_SWEEP] <= 1'b0;
        ctrl_ff[`SRC_B_BURST] <= 1'b0;
      end
      if (warnGo) begin
        warnCnt_ff <= WARN_CYCLES;
      end else if (warnRun) begin
        warnCnt_ff <= warnCnt_ff - 32'h1;
      end
    end
  end

  // remaining writable registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      initF_ff  <= 32'h0;
      maxF_ff   <= 32'h0;
      upStep_ff <= 32'h1;
      dnStep_ff <= 32'h1;
      slowN_ff  <= `SRC_CNT_W'(1);
      stopN_ff  <= `SRC_CNT_W'(1);
      burstN_ff <= `SRC_CNT_W'(1);
      wait_ff   <= 32'h0;
      sweepT_ff <= 32'h0;
    end else if (wrStb) begin
      if (isAdr(adr, `SRC_ADR_INITF))  initF_ff  <= pwdata;
      if (isAdr(adr, `SRC_ADR_MAXF))   maxF_ff   <= pwdata;
      if (isAdr(adr, `SRC_ADR_UPSTEP)) upStep_ff <= pwdata;
      if (isAdr(adr, `SRC_ADR_DNSTEP)) dnStep_ff <= pwdata;
      if (isAdr(adr, `SRC_ADR_SLOWN))  slowN_ff  <= pwdata[`SRC_CNT_W-1:0];
      if (isAdr(adr, `SRC_ADR_STOPN))  stopN_ff  <= pwdata[`SRC_CNT_W-1:0];
      if (isAdr(adr, `SRC_ADR_BURSTN)) burstN_ff <= pwdata[`SRC_CNT_W-1:0];
      if (isAdr(adr, `SRC_ADR_WAIT))   wait_ff   <= pwdata;
      if (isAdr(adr, `SRC_ADR_SWEEPT)) sweepT_ff <= pwdata;
    end
  end

  // read data is captured in the setup cycle
  logic [31:0] rdMux;
  always_comb begin
    case (adr)
      `SRC_ADR_CTRL:   rdMux = {24'h0, ctrl_ff};
      `SRC_ADR_STAT:   rdMux = {22'h0, outOn_ff, warnRun, 1'b0, state_ff};
      `SRC_ADR_INITF:  rdMux = initF_ff;
      `SRC_ADR_MAXF:   rdMux = maxF_ff;
      `SRC_ADR_UPSTEP: rdMux = upStep_ff;
      `SRC_ADR_DNSTEP: rdMux = dnStep_ff;
      `SRC_ADR_SLOWN:  rdMux = {7'h0, slowN_ff};
      `SRC_ADR_STOPN:  rdMux = {7'h0, stopN_ff};
      `SRC_ADR_WAIT:   rdMux = wait_ff;
      `SRC_ADR_BURSTN: rdMux = {7'h0, burstN_ff};
      `SRC_ADR_SWEEPT: rdMux = sweepT_ff;
      `SRC_ADR_PCNT:   rdMux = {7'h0, pulseCnt_ff};
      default:         rdMux = 32'h0;
    endcase
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_ff <= 32'h0;
    end else if (setup && !pwrite) begin
      prdata_ff <= adrHit ? rdMux : 32'h0;
    end
  end

  // outputs; stopped means both pulse outputs rest low/off
  assign freqWord        = freq_ff;
  assign frontPulse      = pulse_ff;
  assign openCollectorOn = pulse_ff & motorEn;
  assign sweepActive     = sweep_ff;
  assign sweepStart      = nxt_sweep & ~sweep_ff;
  assign warnShow        = warnRun;
endmodule // src_ramp_trig_ctrl

// [inc/src_cfg.svh]
// constants for the stepper ramp and trigger control block
`ifndef SRC_CFG_SVH
`define SRC_CFG_SVH
`define SRC_ADR_CTRL   8'h00
`define SRC_ADR_STAT   8'h04
`define SRC_ADR_INITF  8'h08
`define SRC_ADR_MAXF   8'h0C
`define SRC_ADR_UPSTEP 8'h10
`define SRC_ADR_DNSTEP 8'h14
`define SRC_ADR_SLOWN  8'h18
`define SRC_ADR_STOPN  8'h1C
`define SRC_ADR_WAIT   8'h20
`define SRC_ADR_BURSTN 8'h24
`define SRC_ADR_SWEEPT 8'h28
`define SRC_ADR_PCNT   8'h2C
`define SRC_B_RUN      0
`define SRC_B_MODE_LO  1
`define SRC_B_MODE_HI  2
`define SRC_B_RAMPB    3
`define SRC_B_MOTOR    4
`define SRC_B_POLNEG   5
`define SRC_B_SWEEP    6
`define SRC_B_BURST    7
`define SRC_CTRL_W     8
`define SRC_CTRL_RST   8'h00
`define SRC_CNT_W      25
`define SRC_CLK_KHZ    40000
`define SRC_WARN_MS    1000
`define SRC_WARN_CYC   (`SRC_WARN_MS * `SRC_CLK_KHZ)
`endif

// [inc/src_pkg.sv]
// types shared by the stepper ramp and trigger control block
package src_pkg;
  typedef enum logic [6:0] {
    SRC_IDLE = 7'h01,
    SRC_UP   = 7'h02,
    SRC_MAX  = 7'h04,
    SRC_DN   = 7'h08,
    SRC_LOW  = 7'h10,
    SRC_WAIT = 7'h20,
    SRC_RUN  = 7'h40
  } src_state_t;
  typedef enum logic [1:0] {
    SRC_CONT = 2'h0,
    SRC_TRIG = 2'h1,
    SRC_GATE = 2'h2
  } src_mode_t;
endpackage

// [verif/src_ramp_trig_chk.sv]
// port-level assertion checker for the ramp and trigger control block
`timescale 1ns/10ps
module src_ramp_trig_chk #(
  parameter int unsigned WARN_CYCLES = 20
) (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] freqWord,
  input wire logic        frontPulse,
  input wire logic        openCollectorOn,
  input wire logic        sweepStart,
  input wire logic        sweepActive,
  input wire logic        warnShow
);
  logic [31:0] wcnt_ff;
  logic [31:0] nxt_wcnt;
  wire         badAddr = (paddr > 8'h2C) || (paddr[1:0] != 2'h0);
  // length of the warning window; restarts whenever it drops
  assign nxt_wcnt = warnShow ? wcnt_ff + 32'h1 : 32'h0;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) wcnt_ff <= 32'h0;
    else wcnt_ff <= nxt_wcnt;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // bus answers, then pin behaviour
  ready_high_a: assert property (pready) else $error("pready low");
  bad_addr_a: assert property (psel && penable && badAddr |-> pslverr)
    else $error("no error on bad address");
  read_zero_a: assert property (psel && penable && !pwrite && badAddr |-> prdata == 32'h0)
    else $error("bad address read not zero");
  good_addr_a: assert property (psel && penable && !badAddr |-> !pslverr)
    else $error("error on good address");
  oc_pulse_a: assert property (openCollectorOn |-> frontPulse)
    else $error("open collector on without pulse");
  sweep_start_a: assert property (sweepStart |=> sweepActive)
    else $error("sweep start without sweep");
  sweep_rise_a: assert property ($rose(sweepActive) |-> $past(sweepStart))
    else $error("sweep began unannounced");
  pulse_freq_a: assert property ($rose(frontPulse) |-> freqWord != 32'h0)
    else $error("pulse edge at zero frequency");
  warn_len_a: assert property ($fell(warnShow) |->
      wcnt_ff + 32'h1 >= WARN_CYCLES && wcnt_ff <= WARN_CYCLES + 1)
    else $error("warning length wrong");
  warn_max_a: assert property (wcnt_ff <= WARN_CYCLES + 1)
    else $error("warning too long");
endmodule // src_ramp_trig_chk

bind src_ramp_trig_ctrl src_ramp_trig_chk #(.WARN_CYCLES(WARN_CYCLES)) chk (
  .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .freqWord(freqWord), .frontPulse(frontPulse), .openCollectorOn(openCollectorOn),
  .sweepStart(sweepStart), .sweepActive(sweepActive), .warnShow(warnShow));

// [verif/src_motor_model.sv]
// stepper driver and trigger source model for the ramp bench
`timescale 1ns/10ps
module src_motor_model (
  input  wire logic ref_clk,
  input  wire logic frontPulse,
  input  wire logic openCollectorOn,
  output logic      rearTrigPin,
  output logic      motor_start_pin,
  output logic      motor_slowdown_stop_pin
);
  int unsigned cyc = 0;
  int unsigned steps = 0;
  logic        pulseDly = 1'b0;
  logic        ocDly = 1'b0;
  initial begin
    rearTrigPin = 1'b0;
    motor_start_pin = 1'b0;
    motor_slowdown_stop_pin = 1'b0;
  end
  // driver steps on each rising edge of the open-collector line
  always @(posedge ref_clk) begin
    pulseDly <= frontPulse;
    ocDly <= openCollectorOn;
    if (frontPulse && !pulseDly) cyc <= cyc + 1;
    if (openCollectorOn && !ocDly) steps <= steps + 1;
  end
  // one pin moves at a time, held long enough for the synchronisers
  task drv(input int k, input logic v);
    @(posedge ref_clk);
    case (k)
      0: rearTrigPin <= v;
      1: motor_start_pin <= v;
      default: motor_slowdown_stop_pin <= v;
    endcase
    repeat (4) @(posedge ref_clk);
  endtask
endmodule // src_motor_model

// [verif/src_ramp_trig_ctrl_tb.sv]
// self-checking bench for the ramp and trigger control block
`timescale 1ns/10ps
`include "src_cfg.svh"
module src_ramp_trig_ctrl_tb;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        manual_fire_key = 1'b0;
  logic [31:0] prdata, freqWord, rdv;
  logic        pready, pslverr, frontPulse, openCollectorOn, errv, warnShow;
  logic        rearTrigPin, motor_start_pin, motor_slowdown_stop_pin;
  int          failures = 0;
  int          n_compared = 0;
  int unsigned bc, bs;
  always #12.5 ref_clk = ~ref_clk;
  src_ramp_trig_ctrl #(.WARN_CYCLES(20)) DUT (.ref_clk(ref_clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rearTrigPin(rearTrigPin),
    .motor_start_pin(motor_start_pin), .motor_slowdown_stop_pin(motor_slowdown_stop_pin),
    .manual_fire_key(manual_fire_key), .freqWord(freqWord), .frontPulse(frontPulse),
    .openCollectorOn(openCollectorOn), .sweepStart(), .sweepActive(), .warnShow(warnShow));
  src_motor_model mdl (.ref_clk(ref_clk), .frontPulse(frontPulse),
    .openCollectorOn(openCollectorOn), .rearTrigPin(rearTrigPin),
    .motor_start_pin(motor_start_pin), .motor_slowdown_stop_pin(motor_slowdown_stop_pin));
  task wrap_up;
    $display("compared %0d mismatched %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task tmo;
    failures++;
    $display("[ERR] %0t wait ran out", $time);
    wrap_up();
  endtask
  // one bus transfer; waits for pready under a bound
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (n > 20) tmo();
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdv, exp);
  endtask
  task waitFreq(input logic [31:0] f);
    int n;
    n = 0;
    while (freqWord !== f) begin
      @(posedge ref_clk);
      n++;
      if (n > 400) tmo();
    end
    chk(freqWord, f);
  endtask
  task waitIdle;
    int n;
    n = 0;
    do begin
      apb(1'b0, `SRC_ADR_STAT, 32'h0);
      n++;
      if (n > 80) tmo();
    end while (rdv[6:0] !== 7'h01);
  endtask
  task mark;
    bc = mdl.cyc;
    bs = mdl.steps;
  endtask
  // edge on a pin (or a key press), then count output cycles
  task shot(input int k, input logic [31:0] exp);
    mark();
    if (k < 2) begin
      mdl.drv(k, 1'b1);
      mdl.drv(k, 1'b0);
    end else begin
      @(posedge ref_clk);
      manual_fire_key <= 1'b1;
      // held past half a waveform cycle so a gated run shows one pulse
      repeat (12) @(posedge ref_clk);
      manual_fire_key <= 1'b0;
    end
    repeat (60) @(posedge ref_clk);
    chk(mdl.cyc - bc, exp);
  endtask
  // main sequence: reset, registers, trigger modes, motor profiles
  initial begin
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(`SRC_ADR_CTRL, 32'h0);
    rd(`SRC_ADR_STAT, 32'h1);
    rd(8'h30, 32'h0);
    chk(32'(errv), 32'h1);
    rd(8'h06, 32'h0);
    chk(32'(errv), 32'h1);
    wr(8'h01, 32'hFF);
    rd(`SRC_ADR_CTRL, 32'h0);
    wr(`SRC_ADR_INITF, 32'h10000000);
    wr(`SRC_ADR_MAXF, 32'h20000000);
    wr(`SRC_ADR_UPSTEP, 32'h01000000);
    wr(`SRC_ADR_DNSTEP, 32'h01000000);
    wr(`SRC_ADR_BURSTN, 32'h3);
    wr(`SRC_ADR_SLOWN, 32'h4);
    wr(`SRC_ADR_STOPN, 32'h8);
    wr(`SRC_ADR_WAIT, 32'hA);
    $display("test regs done");
    wr(`SRC_ADR_CTRL, 32'h3);
    shot(0, 32'h1);
    shot(1, 32'h1);
    shot(2, 32'h1);
    mdl.drv(0, 1'b1);
    repeat (60) @(posedge ref_clk);
    shot(2, 32'h0);
    mdl.drv(0, 1'b0);
    wr(`SRC_ADR_CTRL, 32'h23);
    mark();
    mdl.drv(0, 1'b1);
    repeat (60) @(posedge ref_clk);
    chk(mdl.cyc - bc, 32'h0);
    mdl.drv(0, 1'b0);
    repeat (60) @(posedge ref_clk);
    chk(mdl.cyc - bc, 32'h1);
    wr(`SRC_ADR_CTRL, 32'h83);
    shot(0, 32'h3);
    mark();
    mdl.drv(0, 1'b1);
    mdl.drv(0, 1'b0);
    mdl.drv(0, 1'b1);
    mdl.drv(0, 1'b0);
    repeat (60) @(posedge ref_clk);
    chk(mdl.cyc - bc, 32'h3);
    // sweep of 64 clocks at 16 clocks per cycle, second edge inside it
    wr(`SRC_ADR_SWEEPT, 32'h40);
    wr(`SRC_ADR_CTRL, 32'h43);
    mark();
    mdl.drv(0, 1'b1);
    mdl.drv(0, 1'b0);
    mdl.drv(0, 1'b1);
    mdl.drv(0, 1'b0);
    repeat (80) @(posedge ref_clk);
    chk(mdl.cyc - bc, 32'h4);
    $display("test triggers done");
    wr(`SRC_ADR_CTRL, 32'h13);
    mark();
    mdl.drv(0, 1'b1);
    mdl.drv(2, 1'b1);
    mdl.drv(2, 1'b0);
    waitFreq(32'h20000000);
    repeat (4) @(posedge ref_clk);
    chk(freqWord, 32'h20000000);
    waitIdle();
    chk(mdl.steps - bs, 32'h8);
    chk(32'(frontPulse | openCollectorOn), 32'h0);
    mdl.drv(0, 1'b0);
    wr(`SRC_ADR_STOPN, 32'h28);
    wr(`SRC_ADR_CTRL, 32'h1B);
    mark();
    mdl.drv(0, 1'b1);
    waitFreq(32'h20000000);
    waitFreq(32'h10000000);
    mdl.drv(2, 1'b1);
    rd(`SRC_ADR_STAT, 32'h1);
    chk(32'(mdl.steps - bs < 40), 32'h1);
    mdl.drv(2, 1'b0);
    mdl.drv(0, 1'b0);
    $display("test profiles done");
    wr(`SRC_ADR_STOPN, 32'h8);
    wr(`SRC_ADR_CTRL, 32'h41);
    wr(`SRC_ADR_CTRL, 32'h51);
    repeat (2) @(posedge ref_clk);
    chk(32'(warnShow), 32'h1);
    repeat (30) @(posedge ref_clk);
    rd(`SRC_ADR_CTRL, 32'h11);
    mark();
    repeat (400) @(posedge ref_clk);
    chk(32'(mdl.steps - bs > 8), 32'h1);
    wr(`SRC_ADR_CTRL, 32'h0);
    wr(`SRC_ADR_CTRL, 32'h15);
    rd(`SRC_ADR_CTRL, 32'h11);
    wr(`SRC_ADR_CTRL, 32'h85);
    rd(`SRC_ADR_CTRL, 32'h85);
    mark();
    mdl.drv(0, 1'b1);
    repeat (100) @(posedge ref_clk);
    chk(32'(mdl.cyc - bc > 4), 32'h1);
    mdl.drv(0, 1'b0);
    repeat (20) @(posedge ref_clk);
    shot(3, 32'h1);
    $display("test modes done");
    wr(`SRC_ADR_CTRL, 32'h0);
    wrap_up();
  end
  // overall guard against a hang
  initial begin
    #2500000;
    tmo();
  end
endmodule // src_ramp_trig_ctrl_tb
